//--- core/memory_map_address_decoder.v
// Purpose: decodes the 16-Mbyte linear map and routes each access
// Assumes: one request per port per cycle, inputs synchronous
// Notes:   answers are registered, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.vh"
module memory_map_address_decoder #(
  parameter PROT_GROUPS = 8,
  parameter STANDBY_SRAM_BASE  = 24'h00_8000
) (
  input  wire                   sys_clk,
  input  wire                   rst_n,
  // Fetch unit port
  input  wire                   pfReq,
  input  wire [23:0]            pfAddr,
  input  wire                   pfWrite,
  input  wire                   pfWord,
  input  wire                   pfProgOp,
  input  wire                   pfEraseOp,
  // Data unit port
  input  wire                   dtReq,
  input  wire [23:0]            dtAddr,
  input  wire                   dtWrite,
  input  wire                   dtWord,
  input  wire                   dtBitOp,
  input  wire                   dtGprOp,
  input  wire [3:0]             dtGprNum,
  input  wire                   dtGprByte,
  input  wire [23:0]            ctxBase,
  // Configuration levels
  input  wire                   extBusMode,
  input  wire                   sbramAlt,
  input  wire [13:0]            psramProtSize,
  input  wire [PROT_GROUPS-1:0] flashWrProt,
  input  wire                   flashRdProt,
  input  wire                   pwUnlock,
  // Fetch side answer
  output reg                    pfAck_ff,
  output reg  [3:0]             pfTarget_ff,
  output reg  [23:0]            pfRouteAddr_ff,
  output reg                    pfReject_ff,
  output reg                    pfLineRd_ff,
  output reg  [5:0]             pfSector_ff,
  output reg  [5:0]             pfBlock_ff,
  // Data side answer
  output reg                    dtAck_ff,
  output reg  [3:0]             dtTarget_ff,
  output reg  [23:0]            dtRouteAddr_ff,
  output reg                    dtByteEn1_ff,
  output reg                    dtByteEn0_ff,
  output reg                    dtBitOk_ff,
  output reg                    dtNoPipeOpt_ff,
  output reg                    dtSysBus_ff,
  output reg                    dtReject_ff
);

  localparam NREG = 19;
  localparam [24*NREG-1:0] LOS = {
    `EXT0_START, `DATA_SRAM_START, `XREG_START, `ESREG_START, `DUAL_PORT_RAM_START,
    `SREG_START, `EXT1_START, `CAN_START, `SER_START, `CANALT_START,
    `SERALT_START, `EXTIO_START, `EXT2_START, `FL0_START, `FL1_START,
    `PROGRAM_SRAM_START, `EMULATED_PROGRAM_SRAM_START, `FIF_START, `DUAL_PORT_RAM_BIT_START};
  localparam [24*NREG-1:0] HIS = {
    `EXT0_END, `DATA_SRAM_END, `XREG_END, `ESREG_END, `DUAL_PORT_RAM_END,
    `SREG_END, `EXT1_END, `CAN_END, `SER_END, `CANALT_END,
    `SERALT_END, `EXTIO_END, `EXT2_END, `FL0_END, `FL1_END,
    `PROGRAM_SRAM_END, `EMULATED_PROGRAM_SRAM_END, `FIF_END, `DUAL_PORT_RAM_END};

  wire [NREG-1:0] pfHit;
  wire [NREG-1:0] dtHit;
  wire [23:0]     gprAddr;
  wire [23:0]     dtEff;

  gpr_bank_map uGpr (
    .ctxBase (ctxBase),
    .regNum  (dtGprNum),
    .byteReg (dtGprByte),
    .regAddr (gprAddr)
  );

  assign dtEff = dtGprOp ? gprAddr : dtAddr;

  // flat 24-bit space
  // One comparator pair per region for each port
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : gReg
      region_match #(
        .LO (LOS[24*(NREG-1-g) +: 24]),
        .HI (HIS[24*(NREG-1-g) +: 24])
      ) uPf (
        .addr (pfAddr),
        .hit  (pfHit[g])
      );
      region_match #(
        .LO (LOS[24*(NREG-1-g) +: 24]),
        .HI (HIS[24*(NREG-1-g) +: 24])
      ) uDt (
        .addr (dtEff),
        .hit  (dtHit[g])
      );
    end
  endgenerate

  // Index names into the hit vectors
  localparam I_EXT0 = 0,  I_DATA_SRAM = 1, I_XREG = 2,  I_ESREG = 3;
  localparam I_DUAL_PORT_RAM = 4, I_SREG = 5,  I_EXT1 = 6,  I_CAN = 7;
  localparam I_SER = 8,   I_CANA = 9,  I_SERA = 10, I_EXTIO = 11;
  localparam I_EXT2 = 12, I_FL0 = 13,  I_FL1 = 14,  I_PROGRAM_SRAM = 15;
  localparam I_EPS = 16,  I_FIF = 17,  I_DPBIT = 18;

  // Classify an address from its hit vector
  function [3:0] classify;
    input [NREG-1:0] h;
    input [23:0]     a;
    input            sbAlt;
    input            ext;
    begin
      classify = `TGT_NONE;
      if (a[23:16] == `SYS_SEG) begin
        if (h[I_DATA_SRAM])
          classify = `TGT_DATA_SRAM;
        else if (h[I_XREG])
          classify = `TGT_XREG;
        else if (h[I_ESREG])
          classify = `TGT_ESREG;
        else if (h[I_DUAL_PORT_RAM])
          classify = `TGT_DUAL_PORT_RAM;
        else if (h[I_SREG])
          classify = `TGT_SREG;
        else if (sbAlt && a >= STANDBY_SRAM_BASE && a < STANDBY_SRAM_BASE + 24'h00_2000)
          classify = `TGT_STANDBY_SRAM;
        else if (h[I_EXT0])
          classify = `TGT_EXT;
      end else if (h[I_CAN] || h[I_SER] || h[I_CANA] || h[I_SERA])
        classify = `TGT_LOCAL;
      else if (h[I_EXT1] || h[I_EXT2] || h[I_EXTIO])
        classify = `TGT_EXT;
      else if (h[I_FL0])
        classify = `TGT_FLASH0;
      else if (h[I_FL1])
        classify = `TGT_FLASH1;
      else if (h[I_PROGRAM_SRAM])
        classify = `TGT_PROGRAM_SRAM;
      else if (h[I_EPS])
        classify = `TGT_EMULATED_PROGRAM_SRAM;
      else if (h[I_FIF])
        classify = `TGT_FIF;
      // reserved or unmapped goes external in bus mode
      if (classify == `TGT_NONE && ext)
        classify = `TGT_EXT;
    end
  endfunction

  wire [3:0] pfCls = classify(pfHit, pfAddr, sbramAlt, extBusMode);
  wire [3:0] dtCls = classify(dtHit, dtEff, sbramAlt, extBusMode);

  // Flash protection and program SRAM protection for the fetch side
  wire [5:0] pfSec   = {pfAddr[18], pfAddr[16:12]};
  wire       pfFlash = (pfCls == `TGT_FLASH0) || (pfCls == `TGT_FLASH1);
  wire       pfRes   = pfHit[I_FL0] && pfAddr >= `FLRES_START &&
                       pfAddr <= `FLRES_END;
  wire [31:0] grpIdx = {26'h000_0000, pfSec} % PROT_GROUPS;
  wire       grpProt = flashWrProt[grpIdx];
  reg        pfRej;
  always @* begin
    pfRej = 1'b0;
    if (pfFlash && (pfWrite || pfProgOp || pfEraseOp)) begin
      if ((grpProt && !pwUnlock) || pfRes)
        pfRej = 1'b1;
    end else if (pfFlash && !pfWrite) begin
      if (flashRdProt && !pwUnlock)
        pfRej = 1'b1;
    end
    if (pfCls == `TGT_PROGRAM_SRAM && pfWrite &&
        pfAddr[13:0] < psramProtSize)
      pfRej = 1'b1;
  end

  // Data side needs the system bus for program memories, local and external targets
  wire dtViaSys = (dtCls == `TGT_FLASH0) || (dtCls == `TGT_FLASH1) ||
                  (dtCls == `TGT_PROGRAM_SRAM)  || (dtCls == `TGT_EMULATED_PROGRAM_SRAM) ||
                  (dtCls == `TGT_LOCAL)  || (dtCls == `TGT_EXT);
  wire dtBitLegal = dtGprOp || dtHit[I_DPBIT] ||
                    (dtCls == `TGT_SREG) || (dtCls == `TGT_ESREG);
  wire dtRej = (dtBitOp && !dtBitLegal) ||
               (dtViaSys && dtWrite && (dtCls == `TGT_FLASH0 ||
                dtCls == `TGT_FLASH1) && flashWrProt != 0 && !pwUnlock) ||
               (dtViaSys && !dtWrite && (dtCls == `TGT_FLASH0 ||
                dtCls == `TGT_FLASH1) && flashRdProt && !pwUnlock);

  // fetch port: own channel, runs beside data port
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pfAck_ff       <= 1'b0;
      pfTarget_ff    <= `TGT_NONE;
      pfRouteAddr_ff <= 24'h00_0000;
      pfReject_ff    <= 1'b0;
      pfLineRd_ff    <= 1'b0;
      pfSector_ff    <= 6'h00;
      pfBlock_ff     <= 6'h00;
    end else begin
      pfAck_ff       <= pfReq;
      pfTarget_ff    <= pfReq ? pfCls : `TGT_NONE;
      pfRouteAddr_ff <= pfAddr;
      pfReject_ff    <= pfReq && pfRej;
      pfLineRd_ff    <= pfReq && pfFlash && !pfWrite;
      if (pfFlash && !pfWrite)
        pfRouteAddr_ff <= {pfAddr[23:`FLASH_LINE_LSB], 4'h0};
      pfSector_ff    <= pfSec;
      pfBlock_ff     <= {1'b0, pfAddr[11:`BLOCK_LSB]};
    end
  end

  // data port: independent of fetch port
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dtAck_ff       <= 1'b0;
      dtTarget_ff    <= `TGT_NONE;
      dtRouteAddr_ff <= 24'h00_0000;
      dtByteEn1_ff   <= 1'b0;
      dtByteEn0_ff   <= 1'b0;
      dtBitOk_ff     <= 1'b0;
      dtNoPipeOpt_ff <= 1'b0;
      dtSysBus_ff    <= 1'b0;
      dtReject_ff    <= 1'b0;
    end else begin
      dtAck_ff       <= dtReq;
      dtTarget_ff    <= dtReq ? dtCls : `TGT_NONE;
      // word aligned even, byte keeps address
      dtRouteAddr_ff <= dtWord ? {dtEff[23:1], 1'b0} : dtEff;
      dtByteEn0_ff   <= dtReq && (dtWord || !dtEff[0]);
      dtByteEn1_ff   <= dtReq && (dtWord || dtEff[0]);
      dtBitOk_ff     <= dtReq && dtBitOp && dtBitLegal;
      dtNoPipeOpt_ff <= dtReq && dtHit[I_EXTIO];
      dtSysBus_ff    <= dtReq && dtViaSys;
      dtReject_ff    <= dtReq && dtRej;
    end
  end

endmodule
`default_nettype wire

//--- inc/mem_map_consts.vh
// Purpose: address map constants for the memory map decoder
// Assumes: 24-bit byte addresses, segment in bits 23:16
// Notes:   start and end values are inclusive
`ifndef MEM_MAP_CONSTS_VH
`define MEM_MAP_CONSTS_VH

`define ADDR_W          24
`define SEG_LSB         16
`define PAGE_LSB        14
`define SYS_SEG         8'h00

`define EXT0_START      24'h00_0000
`define EXT0_END        24'h00_7FFF
`define DATA_SRAM_START     24'h00_A000
`define DATA_SRAM_END       24'h00_DFFF
`define XREG_START      24'h00_E000
`define XREG_END        24'h00_EFFF
`define ESREG_START     24'h00_F000
`define ESREG_END       24'h00_F1FF
`define DUAL_PORT_RAM_START     24'h00_F600
`define DUAL_PORT_RAM_END       24'h00_FDFF
`define DUAL_PORT_RAM_BIT_START 24'h00_FD00
`define SREG_START      24'h00_FE00
`define SREG_END        24'h00_FFFF
`define EXT1_START      24'h01_0000
`define EXT1_END        24'h1F_FFFF
`define CAN_START       24'h20_0000
`define CAN_END         24'h20_3FFF
`define SER_START       24'h20_4000
`define SER_END         24'h20_57FF
`define CANALT_START    24'h20_8000
`define CANALT_END      24'h20_AFFF
`define SERALT_START    24'h20_B000
`define SERALT_END      24'h20_BBFF
`define EXTIO_START     24'h21_0000
`define EXTIO_END       24'h3F_FFFF
`define EXT2_START      24'h40_0000
`define EXT2_END        24'hBF_FFFF
`define FL0_START       24'hC0_0000
`define FL0_END         24'hC3_FFFF
`define FLRES_START     24'hC0_F000
`define FLRES_END       24'hC0_FFFF
`define FL1_START       24'hC4_0000
`define FL1_END         24'hC4_FFFF
`define PROGRAM_SRAM_START     24'hE0_0000
`define PROGRAM_SRAM_END       24'hE0_3FFF
`define EMULATED_PROGRAM_SRAM_START    24'hE8_0000
`define EMULATED_PROGRAM_SRAM_END      24'hE8_3FFF
`define FIF_START       24'hFF_FF00
`define FIF_END         24'hFF_FFFF

`define SECTOR_LSB      12
`define BLOCK_LSB       7
`define FLASH_LINE_LSB  4

// Target codes
`define TGT_NONE        4'h0
`define TGT_FLASH0      4'h1
`define TGT_FLASH1      4'h2
`define TGT_PROGRAM_SRAM       4'h3
`define TGT_DATA_SRAM       4'h4
`define TGT_DUAL_PORT_RAM       4'h5
`define TGT_SREG        4'h6
`define TGT_ESREG       4'h7
`define TGT_XREG        4'h8
`define TGT_STANDBY_SRAM       4'h9
`define TGT_LOCAL       4'hA
`define TGT_EXT         4'hB
`define TGT_FIF         4'hC
`define TGT_EMULATED_PROGRAM_SRAM      4'hD

`endif

//--- core/region_match.v
// Purpose: inclusive address range comparator, one per region for each port
// Assumes: bounds are constants
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module region_match #(
  parameter [23:0] LO = 24'h00_0000,
  parameter [23:0] HI = 24'h00_0000
) (
  input  wire [23:0] addr,
  output wire        hit
);
  // Both bounds inclusive
  assign hit = (addr >= LO) && (addr <= HI);
endmodule
`default_nettype wire

//--- core/gpr_bank_map.v
// Purpose: maps a general register number to a dual-port RAM address
// Assumes: context base is word aligned
// Notes:   byte registers use low/high byte of words 0..7
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.vh"
module gpr_bank_map (
  input  wire [23:0] ctxBase,
  input  wire [3:0]  regNum,
  input  wire        byteReg,
  output wire [23:0] regAddr
);
  wire [4:0] offs;
  // Byte register n: word n>>1, high byte when n is odd
  assign offs    = byteReg ? {1'b0, regNum[3:1], regNum[0]}
                           : {regNum, 1'b0};
  assign regAddr = ctxBase + {19'h0_0000, offs};
endmodule
`default_nettype wire

//--- verif/mem_map_checker_assertions.sv
// Purpose: port-level checks of the memory map decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   every answer lands one edge after its request
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.vh"
module mem_map_checker (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        pfReq,
  input wire [23:0] pfAddr,
  input wire        pfWrite,
  input wire        dtReq,
  input wire [23:0] dtAddr,
  input wire        dtWord,
  input wire        dtBitOp,
  input wire        dtGprOp,
  input wire        pfAck_ff,
  input wire        pfReject_ff,
  input wire        dtAck_ff,
  input wire [3:0]  dtTarget_ff,
  input wire        dtByteEn0_ff,
  input wire        dtByteEn1_ff,
  input wire        dtBitOk_ff,
  input wire        dtNoPipeOpt_ff
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Address access, not a register-number access
  wire dtPlain = dtReq && !dtGprOp;
  // Inclusive window, so both end addresses are exercised
  function automatic logic inR(input logic [23:0] a, lo, hi);
    return a >= lo && a <= hi;
  endfunction
  property p_ack;
    (pfReq |=> pfAck_ff) and (dtReq |=> dtAck_ff);
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_data_sram;
    dtPlain && inR(dtAddr, `DATA_SRAM_START, `DATA_SRAM_END) |=>
      dtTarget_ff == `TGT_DATA_SRAM;
  endproperty
  a_data_sram: assert property (p_data_sram) else $error("data SRAM missed");
  property p_dual_port_ram;
    dtPlain && inR(dtAddr, `DUAL_PORT_RAM_START, `DUAL_PORT_RAM_END) |=> dtTarget_ff == `TGT_DUAL_PORT_RAM;
  endproperty
  a_dual_port_ram: assert property (p_dual_port_ram) else $error("dual-port RAM missed");
  property p_local;
    dtPlain && inR(dtAddr, `CAN_START, `SER_END) |=>
      dtTarget_ff == `TGT_LOCAL;
  endproperty
  a_local: assert property (p_local) else $error("local window missed");
  property p_extio;
    dtPlain && inR(dtAddr, `EXTIO_START, `EXTIO_END) |=> dtNoPipeOpt_ff;
  endproperty
  a_extio: assert property (p_extio) else $error("I/O ordering lost");
  property p_word;
    dtPlain && dtWord |=> dtByteEn0_ff && dtByteEn1_ff;
  endproperty
  a_word: assert property (p_word) else $error("word lanes wrong");
  property p_flres;
    pfReq && pfWrite && inR(pfAddr, `FLRES_START, `FLRES_END) |=> pfReject_ff;
  endproperty
  a_flres: assert property (p_flres) else $error("sector not held");
  property p_bit;
    dtPlain && dtBitOp && inR(dtAddr, `DUAL_PORT_RAM_BIT_START, `DUAL_PORT_RAM_END) |=> dtBitOk_ff;
  endproperty
  a_bit: assert property (p_bit) else $error("bit access refused");
endmodule
bind memory_map_address_decoder mem_map_checker i_mem_map_checker (.*);
`default_nettype wire

//--- verif/cpu_unit_model.sv
// Purpose: request side of the fetch and data units
// Assumes: the decoder takes a request at the rising edge
// Notes:   released address lines show the inverse, never a stale value
`timescale 1ns/1ps
`default_nettype none
module cpu_unit_model (
  input  wire         sys_clk,
  output logic        pfReq,
  output logic [23:0] pfAddr,
  output logic        pfWrite,
  output logic        pfWord,
  output logic        pfProgOp,
  output logic        pfEraseOp,
  output logic        dtReq,
  output logic [23:0] dtAddr,
  output logic        dtWrite,
  output logic        dtWord,
  output logic        dtBitOp,
  output logic        dtGprOp,
  output logic [3:0]  dtGprNum,
  output logic        dtGprByte
);
  // model never touches unused register addresses
  // Both units idle from time zero
  initial begin
    {pfReq, pfAddr, pfWrite, pfWord, pfProgOp, pfEraseOp} = '0;
    {dtReq, dtAddr, dtWrite, dtWord, dtBitOp, dtGprOp} = '0;
    {dtGprNum, dtGprByte} = '0;
  end
  // fetch unit access
  // One-cycle pulse; f holds write, word, program and erase
  task automatic pfAccess(input logic [23:0] a, input logic [3:0] f);
    @(negedge sys_clk);
    pfReq = 1'b1;
    pfAddr = a;
    {pfWrite, pfWord, pfProgOp, pfEraseOp} = f;
    @(negedge sys_clk);
    pfReq = 1'b0;
    pfAddr = ~a;
  endtask
  // independent data port
  // f holds write, word, bit and register-number select
  task automatic dtAccess(input logic [23:0] a, input logic [3:0] f,
                          input logic [4:0] r);
    @(negedge sys_clk);
    dtReq = 1'b1;
    dtAddr = a;
    {dtWrite, dtWord, dtBitOp, dtGprOp} = f;
    {dtGprByte, dtGprNum} = r;
    @(negedge sys_clk);
    dtReq = 1'b0;
    dtAddr = ~a;
  endtask
endmodule
`default_nettype wire

//--- verif/test_memory_map_address_decoder.sv
// Purpose: self-checking bench of the memory map decoder
// Assumes: answers one edge after a request, inputs move at negedge
// Notes:   table entries carry the target code above the address
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_consts.vh"
module test_memory_map_address_decoder;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        extBusMode = 1'b0;
  logic        sbramAlt = 1'b0;
  logic        flashRdProt = 1'b0;
  logic        pwUnlock = 1'b0;
  logic [13:0] psramProtSize = 14'h0100;
  logic [7:0]  flashWrProt = 8'h00;
  logic [23:0] ctxBase = 24'h00_F600;
  wire         pfReq, pfWrite, pfWord, pfProgOp, pfEraseOp, dtReq;
  wire         dtWrite, dtWord, dtBitOp, dtGprOp, dtGprByte;
  wire  [23:0] pfAddr, dtAddr, pfRouteAddr_ff, dtRouteAddr_ff;
  wire  [3:0]  dtGprNum, pfTarget_ff, dtTarget_ff;
  wire         pfAck_ff, pfReject_ff, pfLineRd_ff, dtAck_ff, dtByteEn1_ff;
  wire         dtByteEn0_ff, dtBitOk_ff, dtNoPipeOpt_ff, dtSysBus_ff;
  wire         dtReject_ff;
  wire  [5:0]  pfSector_ff, pfBlock_ff;
  int          failures = 0;
  int          n_compared = 0;
  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  memory_map_address_decoder i_memory_map_address_decoder (.*);
  cpu_unit_model i_cpu_unit_model (.*);
  // Case equality, so an unknown never passes
  task automatic chk(input string what, input logic [23:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One data access, judged on acknowledge and target
  task automatic dtRun(input logic [23:0] a, input logic [3:0] f, t);
    i_cpu_unit_model.dtAccess(a, f, 5'h00);
    chk("dtAck", 1, dtAck_ff);
    chk("dtTarget", t, dtTarget_ff);
  endtask
  task automatic t_segment0;
    logic [27:0] tab [8] = '{28'h400_A000, 28'h400_DFFF, 28'h800_E000,
      28'h700_F000, 28'h700_F1FF, 28'h500_F600, 28'h500_FDFF, 28'h600_FE00};
    logic w;
    for (int i = 0; i < 8; i++) begin
      w = !i[0];
      dtRun(tab[i][23:0], {i[1], w, 2'b00}, tab[i][27:24]);
      chk("dtByteEn0", w | !tab[i][0], dtByteEn0_ff);
      chk("dtByteEn1", w | tab[i][0], dtByteEn1_ff);
      chk("dtRoute", {tab[i][23:1], tab[i][0] & !w}, dtRouteAddr_ff);
    end
    $display("t_segment0 finished");
  endtask
  task automatic t_external;
    logic [27:0] tab [10] = '{28'hB00_7FFF, 28'hB01_0000, 28'hB40_0000,
      28'hBBF_FFFF, 28'hA20_0000, 28'hA20_57FF, 28'hB20_5800,
      28'hB21_0000, 28'hB3F_FFFF, 28'hCFF_FF00};
    extBusMode = 1'b1;
    for (int i = 0; i < 10; i++) begin
      dtRun(tab[i][23:0], 4'h4, tab[i][27:24]);
      chk("dtNoPipe", tab[i][23:16] >= 8'h21 && tab[i][23:16] <= 8'h3F,
          dtNoPipeOpt_ff);
      chk("dtSysBus", tab[i][27:25] == 3'b101, dtSysBus_ff);
    end
    extBusMode = 1'b0;
    dtRun(24'h20_5800, 4'h4, `TGT_NONE);
    // Standby SRAM only answers while its window is switched on
    sbramAlt = 1'b1;
    dtRun(24'h00_8000, 4'h4, `TGT_STANDBY_SRAM);
    sbramAlt = 1'b0;
    dtRun(24'h00_8000, 4'h4, `TGT_NONE);
    dtRun(24'hE8_0000, 4'h4, `TGT_EMULATED_PROGRAM_SRAM);
    chk("dtSysBus", 1, dtSysBus_ff);
    $display("t_external finished");
  endtask
  task automatic t_fetch;
    fork
      i_cpu_unit_model.pfAccess(24'hC4_3280, 4'h4);
      i_cpu_unit_model.dtAccess(24'h00_A000, 4'h4, 5'h00);
    join
    chk("pfAck", 1, pfAck_ff);
    chk("pfTarget", `TGT_FLASH1, pfTarget_ff);
    chk("dtTarget", `TGT_DATA_SRAM, dtTarget_ff);
    chk("pfSector", 6'h23, pfSector_ff);
    chk("pfBlock", 6'h05, pfBlock_ff);
    i_cpu_unit_model.pfAccess(24'hC0_0010, 4'h4);
    chk("pfTarget", `TGT_FLASH0, pfTarget_ff);
    chk("pfLineRd", 1, pfLineRd_ff);
    chk("pfRoute", 24'hC0_0010, pfRouteAddr_ff);
    i_cpu_unit_model.pfAccess(24'hC0_F000, 4'hD);
    chk("pfReject", 1, pfReject_ff);
    i_cpu_unit_model.pfAccess(24'hE0_00FE, 4'hC);
    chk("pfReject", 1, pfReject_ff);
    i_cpu_unit_model.pfAccess(24'hE0_0100, 4'hC);
    chk("pfReject", 0, pfReject_ff);
    chk("pfTarget", `TGT_PROGRAM_SRAM, pfTarget_ff);
    flashWrProt = 8'h01;
    i_cpu_unit_model.dtAccess(24'hC0_1000, 4'hC, 5'h00);
    chk("dtReject", 1, dtReject_ff);
    pwUnlock = 1'b1;
    i_cpu_unit_model.dtAccess(24'hC0_1000, 4'hC, 5'h00);
    chk("dtReject", 0, dtReject_ff);
    $display("t_fetch finished");
  endtask
  task automatic t_bits;
    dtRun(24'h00_FD00, 4'h2, `TGT_DUAL_PORT_RAM);
    chk("dtBitOk", 1, dtBitOk_ff);
    dtRun(24'h00_F600, 4'h2, `TGT_DUAL_PORT_RAM);
    chk("dtBitOk", 0, dtBitOk_ff);
    ctxBase = 24'h00_F800;
    i_cpu_unit_model.dtAccess(24'h00_0000, 4'h7, 5'h03);
    chk("dtRoute", 24'h00_F806, dtRouteAddr_ff);
    chk("dtBitOk", 1, dtBitOk_ff);
    i_cpu_unit_model.dtAccess(24'h00_0000, 4'h3, 5'h13);
    chk("dtRoute", 24'h00_F803, dtRouteAddr_ff);
    chk("dtByteEn0", 0, dtByteEn0_ff);
    $display("t_bits finished");
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence: reset for three edges, then the scenarios
  initial begin
    repeat (3) @(negedge sys_clk);
    chk("dtTarget", `TGT_NONE, dtTarget_ff);
    rst_n = 1'b1;
    t_segment0();
    t_external();
    t_fetch();
    t_bits();
    wrap_up();
  end
  // Hang guard: a run past its bound counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
